/* rtl/fis_core.sv */
// Notes on behaviour
// - id opcode returns maker, type, capacity MSB first
// - table read start byte is address low byte
// - table data starts after eight dummy clocks
// - register chosen by address bits fifteen to twelve
// - erase needs write enable latch set
// - erase runs only if frame ends after address
// - busy high during self-timed erase, then low
// - lock bit blocks erase and program forever
// - program needs enable, address, one to 256 bytes
// - read takes address, eight dummies, then data
// - read address increments and wraps within register
// - read while busy is ignored, cycle unaffected
// - parameter setting accepted only in quad mode
// - dummy field gives two to eight clocks
// - wrap field gives eight to sixty-four bytes
// - reset restores eight-byte wrap, two dummies
// - wrap length kept across mode change
// - burst read wraps at wrap-length boundary
`timescale 1ns/10ps
module fis_core import fis_pkg::*; #(
  parameter logic [7:0] MAKER_ID = 8'h3C, // arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h61, // arbitrary value
  parameter logic [7:0] CAPACITY = 8'h16, // arbitrary value
  parameter logic [2047:0] PARAM_TABLE = '0,
  parameter int ERASE_WAIT = ERASE_CYCLES,
  parameter int PROG_WAIT = PROG_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic write_enable_latch,
  input wire logic [2:0] security_lock_bits,
  input wire logic quad_command_mode,
  input wire logic reset_command,
  output logic busy,
  output logic [1:0] dummy_count_field,
  output logic [1:0] wrap_length_field,
  output logic [23:0] array_addr,
  input wire logic [7:0] array_rdata
);
  logic [7:0] sec_mem [0:767];
  logic [7:0] prog_buf [0:255];
  logic [255:0] prog_mask_reg;
  logic [7:0] pptr_reg;
  fis_req_t req_reg;
  logic in_frame_reg;
  logic rd_ok_reg;
  logic [5:0] stat_s1_reg;
  logic [5:0] stat_s2_reg;
  logic [7:0] out_sh_reg;
  logic [23:0] out_ptr_reg;
  logic so_reg;
  logic oe_reg;
  logic [23:0] array_addr_reg;
  logic [2:0] cs_sync_reg;
  fis_state_t state_reg;
  logic [7:0] walk_reg;
  logic [15:0] wait_reg;
  logic erase_op_reg;
  logic [1:0] sel_reg;
  logic [1:0] dummy_reg;
  logic [1:0] wrap_reg;

  // link side, on the host clock
  // the frame's own select ends every per-frame state, so nothing here
  // relies on clock edges after the last one of a frame
  wire link_rst_n = arst_n & ~cs_n;
  wire busy_l = stat_s2_reg[5];
  wire quad_l = stat_s2_reg[4];
  wire [1:0] dummy_l = stat_s2_reg[3:2];
  wire [1:0] wrap_l = stat_s2_reg[1:0];

  wire [7:0] byte_in = {req_reg.last[6:0], si};
  wire [CNT_W-1:0] cnt_now = in_frame_reg ? req_reg.bits : '0;
  wire [CNT_W-1:0] cnt_inc = (&cnt_now) ? cnt_now : cnt_now + 1'b1;
  wire opc_done = (cnt_now == OPC_END - 1'b1);
  wire addr_bit = (cnt_now >= OPC_END) && (cnt_now < ADDR_END);
  wire prog_byte = (req_reg.op == OP_SEC_PROG) && (cnt_now >= ADDR_END)
                   && (cnt_now[2:0] == 3'h7);

  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      in_frame_reg <= 1'b0;
    end else begin
      in_frame_reg <= 1'b1;
    end
  end

  // request fields outlive the frame: the clock side reads them after
  // the select has risen, when this clock has stopped
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      req_reg <= '0;
      stat_s1_reg <= '0;
      stat_s2_reg <= '0;
    end else begin
      req_reg.bits <= cnt_inc;
      req_reg.last <= byte_in;
      if (opc_done) begin
        req_reg.op <= byte_in;
      end
      if (addr_bit) begin
        req_reg.addr <= {req_reg.addr[22:0], si};
      end
      stat_s1_reg <= {state_reg != FIS_IDLE, quad_command_mode,
                      dummy_reg, wrap_reg};
      stat_s2_reg <= stat_s1_reg;
    end
  end

  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rd_ok_reg <= 1'b0;
    end else if (opc_done) begin
      rd_ok_reg <= (byte_in == OP_READ_ID) || (byte_in == OP_READ_PARAM)
                   || (byte_in == OP_SEC_READ && !busy_l)
                   || (byte_in == OP_BURST_WRAP && quad_l);
    end
  end

  // program data collects in a page buffer, wrapping inside the register
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      prog_mask_reg <= '0;
      pptr_reg <= 8'h00;
    end else begin
      if (opc_done && byte_in == OP_SEC_PROG) begin
        prog_mask_reg <= '0;
      end else if (prog_byte) begin
        prog_mask_reg[pptr_reg] <= 1'b1;
      end
      if (cnt_now == ADDR_END - 1'b1) begin
        pptr_reg <= {req_reg.addr[6:0], si};
      end else if (prog_byte) begin
        pptr_reg <= pptr_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge sclk) begin
    if (prog_byte) begin
      prog_buf[pptr_reg] <= byte_in;
    end
  end

  // read data path, driven on falling edges
  wire [7:0] op_l = req_reg.op;
  wire [CNT_W-1:0] cnt_l = req_reg.bits;
  wire [CNT_W-1:0] dummy_clks = {{(CNT_W-3){1'b0}}, dummy_l, 1'b0}
                                + 12'h002;
  wire [23:0] wrap_mask = (24'h00_0008 << wrap_l) - 24'h00_0001;
  wire [CNT_W-1:0] data_start = (op_l == OP_READ_ID) ? OPC_END :
                                (op_l == OP_BURST_WRAP) ?
                                ADDR_END + dummy_clks : DATA_START;
  wire [CNT_W-1:0] data_off = cnt_l - data_start;
  wire data_phase = in_frame_reg && rd_ok_reg && (cnt_l >= data_start);
  wire first_load = data_phase && (cnt_l == data_start);
  wire load = data_phase && (data_off[2:0] == 3'h0);

  function automatic logic [23:0] next_addr(input logic [7:0] op,
                                            input logic [23:0] p,
                                            input logic [23:0] m);
    logic [23:0] inc;
    inc = p + 24'h00_0001;
    if (op == OP_READ_ID) begin
      return (p == ID_LAST) ? 24'h00_0000 : inc;
    end
    if (op == OP_BURST_WRAP) begin
      return (p & ~m) | (inc & m);
    end
    return {p[23:8], inc[7:0]};
  endfunction : next_addr

  wire [23:0] start_ptr = (op_l == OP_READ_ID) ? 24'h00_0000 : req_reg.addr;
  wire [23:0] sel_ptr = first_load ? start_ptr
                        : next_addr(op_l, out_ptr_reg, wrap_mask);
  wire [1:0] rd_sel = fis_sec_index(req_reg.addr);
  wire [1:0] rd_row = rd_sel - 2'h1;
  wire [7:0] id_byte = (sel_ptr[1:0] == 2'h0) ? MAKER_ID :
                       (sel_ptr[1:0] == 2'h1) ? MEM_TYPE : CAPACITY;
  wire [7:0] tab_byte = PARAM_TABLE[{sel_ptr[7:0], 3'b000} +: 8];
  // the store is only read while no erase or program is writing it
  wire [7:0] sec_byte = (rd_sel == 2'h0) ? ERASED
                        : sec_mem[{rd_row, sel_ptr[7:0]}];
  wire [7:0] byte_val = (op_l == OP_READ_ID) ? id_byte :
                        (op_l == OP_READ_PARAM) ? tab_byte :
                        (op_l == OP_SEC_READ) ? sec_byte : array_rdata;

  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      out_sh_reg <= 8'h00;
      out_ptr_reg <= 24'h00_0000;
      so_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= data_phase;
      if (load) begin
        so_reg <= byte_val[7];
        out_sh_reg <= {byte_val[6:0], 1'b0};
        out_ptr_reg <= sel_ptr;
      end else if (data_phase) begin
        so_reg <= out_sh_reg[7];
        out_sh_reg <= {out_sh_reg[6:0], 1'b0};
      end
    end
  end

  // array address runs one byte ahead so the array has a byte time
  always_ff @(negedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      array_addr_reg <= 24'h00_0000;
    end else if (in_frame_reg && op_l == OP_BURST_WRAP) begin
      if (cnt_l == ADDR_END) begin
        array_addr_reg <= req_reg.addr;
      end else if (load) begin
        array_addr_reg <= next_addr(op_l, sel_ptr, wrap_mask);
      end
    end
  end

  assign so = so_reg;
  assign so_oe = oe_reg;
  assign array_addr = array_addr_reg;

  // clock side
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cs_sync_reg <= 3'b111;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
    end
  end

  // select rising is the handshake that hands over the request fields
  wire cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
  wire idle = (state_reg == FIS_IDLE);
  wire [1:0] req_sel = fis_sec_index(req_reg.addr);
  wire [1:0] req_row = req_sel - 2'h1;
  wire req_locked = (req_sel != 2'h0) && security_lock_bits[req_row];
  wire wr_ok = cs_rise && idle && write_enable_latch
               && (req_sel != 2'h0) && !req_locked;
  wire erase_go = wr_ok && (req_reg.op == OP_SEC_ERASE)
                  && (req_reg.bits == ADDR_END);
  wire prog_go = wr_ok && (req_reg.op == OP_SEC_PROG)
                 && (req_reg.bits >= ADDR_END + OPC_END)
                 && (req_reg.bits[2:0] == 3'h0);
  wire par_go = cs_rise && idle && quad_command_mode
                && (req_reg.op == OP_SET_PARAM)
                && (req_reg.bits == SET_PARAM_LEN);
  wire wrap_go = cs_rise && idle && !quad_command_mode
                 && (req_reg.op == OP_SET_WRAP)
                 && (req_reg.bits == SET_WRAP_LEN);

  // mode changes never touch these, so the wrap length carries over
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dummy_reg <= DUMMY_RST;
      wrap_reg <= WRAP_RST;
    end else if (reset_command) begin
      dummy_reg <= DUMMY_RST;
      wrap_reg <= WRAP_RST;
    end else if (par_go) begin
      dummy_reg <= req_reg.last[DUMMY_LSB +: 2];
      wrap_reg <= req_reg.last[WRAP_LSB +: 2];
    end else if (wrap_go) begin
      wrap_reg <= req_reg.last[LEGACY_WRAP_LSB +: 2];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= FIS_IDLE;
      walk_reg <= 8'h00;
      wait_reg <= 16'h0000;
      erase_op_reg <= 1'b0;
      sel_reg <= 2'h0;
    end else if (reset_command) begin
      state_reg <= FIS_IDLE;
    end else begin
      case (state_reg)
        FIS_IDLE: begin
          if (erase_go || prog_go) begin
            state_reg <= FIS_WALK;
            walk_reg <= 8'h00;
            erase_op_reg <= erase_go;
            sel_reg <= req_row;
          end
        end
        FIS_WALK: begin
          walk_reg <= walk_reg + 8'h01;
          if (walk_reg == LAST_BYTE) begin
            state_reg <= FIS_WAIT;
            wait_reg <= erase_op_reg ? 16'(ERASE_WAIT) : 16'(PROG_WAIT);
          end
        end
        FIS_WAIT: begin
          wait_reg <= wait_reg - 16'h0001;
          if (wait_reg <= 16'h0001) begin
            state_reg <= FIS_IDLE;
          end
        end
        default: state_reg <= FIS_IDLE;
      endcase
    end
  end

  // page buffer is stable here: its clock stopped with the frame
  always_ff @(posedge clock) begin
    if (state_reg == FIS_WALK) begin
      if (erase_op_reg) begin
        sec_mem[{sel_reg, walk_reg}] <= ERASED;
      end else if (prog_mask_reg[walk_reg]) begin
        sec_mem[{sel_reg, walk_reg}] <= sec_mem[{sel_reg, walk_reg}]
                                        & prog_buf[walk_reg];
      end
    end
  end

  assign busy = (state_reg != FIS_IDLE);
  assign dummy_count_field = dummy_reg;
  assign wrap_length_field = wrap_reg;

  // checks; a reset command aborts a running cycle, so it ends the watch
  erase_start_a: assert property (@(posedge clock)
    disable iff (!arst_n || reset_command) erase_go |=> busy [*8])
    else $error("accepted erase did not raise busy");
  erase_gate_a: assert property (@(posedge clock) disable iff (!arst_n)
    (cs_rise && idle && req_reg.op == OP_SEC_ERASE && !write_enable_latch
     && !reset_command) |=> !busy)
    else $error("erase ran without write enable");
  erase_len_a: assert property (@(posedge clock) disable iff (!arst_n)
    (cs_rise && idle && req_reg.op == OP_SEC_ERASE
     && req_reg.bits != ADDR_END) |=> !busy)
    else $error("erase ran after a bad frame length");
  lock_block_a: assert property (@(posedge clock) disable iff (!arst_n)
    (cs_rise && idle && req_locked) |=> !busy)
    else $error("locked register was altered");
  busy_end_a: assert property (@(posedge clock) disable iff (!arst_n)
    (state_reg == FIS_WAIT && wait_reg == 16'h0001) |=> !busy)
    else $error("busy did not clear at completion");
  param_mode_a: assert property (@(posedge clock) disable iff (!arst_n)
    (cs_rise && !quad_command_mode && req_reg.op == OP_SET_PARAM
     && !reset_command) |=> $stable(dummy_reg))
    else $error("parameter set outside quad mode");
  param_reset_a: assert property (@(posedge clock) disable iff (!arst_n)
    reset_command |=> (dummy_reg == DUMMY_RST && wrap_reg == WRAP_RST))
    else $error("reset did not restore read parameters");
  table_start_a: assert property (@(negedge sclk)
    disable iff (!link_rst_n)
    (in_frame_reg && op_l == OP_READ_PARAM && cnt_l == DATA_START)
    |=> oe_reg)
    else $error("table data did not start on time");
  read_busy_a: assert property (@(negedge sclk)
    disable iff (!link_rst_n)
    (in_frame_reg && op_l == OP_SEC_READ && !rd_ok_reg) |=> !oe_reg)
    else $error("read during busy drove data");
  wrap_bound_a: assert property (@(negedge sclk)
    disable iff (!link_rst_n)
    (load && op_l == OP_BURST_WRAP) |->
    ((sel_ptr & ~wrap_mask) == (req_reg.addr & ~wrap_mask)))
    else $error("burst read left its wrap window");
endmodule : fis_core

/* rtl/fis_pkg.sv */
package fis_pkg;
  localparam logic [7:0] OP_READ_ID = 8'h9F;
  localparam logic [7:0] OP_READ_PARAM = 8'h5A;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SEC_PROG = 8'h42;
  localparam logic [7:0] OP_SEC_READ = 8'h48;
  localparam logic [7:0] OP_SET_PARAM = 8'hC0;
  localparam logic [7:0] OP_BURST_WRAP = 8'h0C;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam int CNT_W = 12;
  // rising edges counted at the end of each phase
  localparam logic [CNT_W-1:0] OPC_END = 12'h008;
  localparam logic [CNT_W-1:0] ADDR_END = 12'h020;
  localparam logic [CNT_W-1:0] DATA_START = 12'h028;
  localparam logic [CNT_W-1:0] SET_PARAM_LEN = 12'h010;
  localparam logic [CNT_W-1:0] SET_WRAP_LEN = 12'h028;
  localparam int SEL_LSB = 12;
  localparam int DUMMY_LSB = 4;
  localparam int WRAP_LSB = 0;
  localparam int LEGACY_WRAP_LSB = 4;
  localparam logic [1:0] DUMMY_RST = 2'h0;
  localparam logic [1:0] WRAP_RST = 2'h0;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] LAST_BYTE = 8'hFF;
  localparam logic [23:0] ID_LAST = 24'h00_0002;
  localparam int ERASE_CYCLES = 1000;
  localparam int PROG_CYCLES = 100;

  typedef enum logic [1:0] {
    FIS_IDLE = 2'b00,
    FIS_WALK = 2'b01,
    FIS_WAIT = 2'b10
  } fis_state_t;

  typedef struct packed {
    logic [7:0] op;
    logic [23:0] addr;
    logic [CNT_W-1:0] bits;
    logic [7:0] last;
  } fis_req_t;

  // 1..3 for a well formed security register address, 0 otherwise
  function automatic logic [1:0] fis_sec_index(input logic [23:0] a);
    logic [3:0] s;
    s = a[SEL_LSB+3:SEL_LSB];
    if (a[23:16] != 8'h00 || a[11:8] != 4'h0 || s == 4'h0 || s > 4'h3)
      return 2'h0;
    return s[1:0];
  endfunction : fis_sec_index
endpackage : fis_pkg

/* testbench/fis_host.sv */
`timescale 1ns/10ps
module fis_host (
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic so,
  input wire logic so_oe,
  output logic saw_oe
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
    saw_oe = 1'b0;
  end
  // mode 0 frame; sclk runs only while cs_n is low, so is taken just
  // before each rise; surplus bits toggle si so stale values never match
  task automatic frame(input logic [63:0] tx, input int ntx,
                       input int ntot, output logic [127:0] rx);
    rx = '0;
    saw_oe = 1'b0;
    #2.3 cs_n = 1'b0;
    for (int i = 0; i < ntot; i++) begin
      si = (i < ntx) ? tx[63-i] : ~si;
      #7.5;
      rx = {rx[126:0], so};
      saw_oe = saw_oe | so_oe;
      sclk = 1'b1;
      #7.5 sclk = 1'b0;
    end
    #7.5 cs_n = 1'b1;
    si = ~si;
  endtask : frame
endmodule : fis_host

/* testbench/tb_fis_core.sv */
`timescale 1ns/10ps
module tb_fis_core;
  import fis_pkg::*;
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  localparam logic [7:0] MTYPE = 8'h61; // arbitrary value
  localparam logic [7:0] CAP = 8'h16; // arbitrary value
  function automatic logic [2047:0] mk_tbl();
    logic [2047:0] t;
    for (int k = 0; k < 256; k++) t[8*k+:8] = 8'(k) ^ 8'h3C;
    return t;
  endfunction : mk_tbl
  localparam logic [2047:0] TBL = mk_tbl();
  logic clock, arst_n, sclk, cs_n, si, so, so_oe, busy, saw_oe;
  logic write_enable_latch, quad_command_mode, reset_command;
  logic [2:0] security_lock_bits;
  logic [1:0] dummy_count_field, wrap_length_field;
  logic [23:0] array_addr;
  logic [7:0] array_rdata;
  logic [127:0] rx;
  logic [63:0] e;
  int fail_count, n_compared, cyc_count, len;
  // main array stand-in: data is a fixed function of the address
  assign array_rdata = array_addr[7:0] ^ 8'h5A;
  fis_core #(.MAKER_ID(MAKER), .MEM_TYPE(MTYPE), .CAPACITY(CAP),
    .PARAM_TABLE(TBL), .ERASE_WAIT(10), .PROG_WAIT(10)) fis_core_inst (
    .clock(clock), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
    .so(so), .so_oe(so_oe), .write_enable_latch(write_enable_latch),
    .security_lock_bits(security_lock_bits),
    .quad_command_mode(quad_command_mode), .reset_command(reset_command),
    .busy(busy), .dummy_count_field(dummy_count_field),
    .wrap_length_field(wrap_length_field), .array_addr(array_addr),
    .array_rdata(array_rdata));
  fis_host fis_host_inst (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so),
    .so_oe(so_oe), .saw_oe(saw_oe));
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc_count++;
    if (cyc_count == 40000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  // leaves cs_n high well past the three cycles the core needs
  task automatic fr(input logic [63:0] tx, input int ntx, input int ntot);
    fis_host_inst.frame(tx, ntx, ntot, rx);
    cyc(5);
  endtask : fr
  task automatic erase(input logic [23:0] a, input int nbits);
    fr({OP_SEC_ERASE, a, 32'd0}, 32, nbits);
  endtask : erase
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 600) begin
      cyc(1);
      n++;
    end
    check({63'd0, busy}, 64'd0);
  endtask : wait_idle
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    write_enable_latch = 1'b0;
    quad_command_mode = 1'b0;
    reset_command = 1'b0;
    security_lock_bits = 3'h0;
    fail_count = 0;
    n_compared = 0;
    cyc_count = 0;
    repeat (6) @(posedge clock);
    #1 arst_n = 1'b1;
    cyc(4);
    check({60'd0, dummy_count_field, wrap_length_field}, 64'd0);
    fr({OP_READ_ID, 56'd0}, 8, 40);
    check({32'd0, rx[31:0]}, {32'd0, MAKER, MTYPE, CAP, MAKER});
    fr({OP_READ_PARAM, 24'h00_00FE, 32'd0}, 32, 64);
    check({40'd0, rx[23:0]}, {40'd0, TBL[2032+:8], TBL[2040+:8],
      TBL[7:0]});
    erase(24'h00_1000, 32);
    check({63'd0, busy}, 64'd0);
    write_enable_latch = 1'b1;
    erase(24'h00_1000, 33);
    check({63'd0, busy}, 64'd0);
    erase(24'h00_4000, 32);
    check({63'd0, busy}, 64'd0);
    erase(24'h00_1000, 32);
    check({63'd0, busy}, 64'd1);
    // a read aimed at the busy register must stay silent
    fr({OP_SEC_READ, 24'h00_1000, 32'd0}, 32, 48);
    check({62'd0, saw_oe, busy}, 64'd1);
    wait_idle();
    check({63'd0, busy}, 64'd0);
    // bytes land at FF then 00: the erased register wraps
    fr({OP_SEC_PROG, 24'h00_10FF, 8'hA5, 8'h3C, 16'd0}, 48, 48);
    check({63'd0, busy}, 64'd1);
    wait_idle();
    fr({OP_SEC_READ, 24'h00_10FE, 32'd0}, 32, 72);
    check({32'd0, rx[31:0]}, 64'h0000_0000_FFA5_3CFF);
    security_lock_bits = 3'h1;
    erase(24'h00_1000, 32);
    check({63'd0, busy}, 64'd0);
    fr({OP_SEC_PROG, 24'h00_1000, 8'h00, 24'd0}, 40, 40);
    check({63'd0, busy}, 64'd0);
    for (int r = 2; r < 4; r++) begin
      erase({8'h00, 4'(r), 12'h000}, 32);
      check({63'd0, busy}, 64'd1);
      wait_idle();
    end
    fr({OP_SET_PARAM, 8'h33, 48'd0}, 16, 16);
    check({60'd0, dummy_count_field, wrap_length_field}, 64'd0);
    fr({OP_SET_WRAP, 24'd0, 8'h20, 24'd0}, 40, 40);
    check({62'd0, wrap_length_field}, 64'd2);
    // burst read outside quad mode must stay silent
    fr({OP_BURST_WRAP, 24'h00_00FC, 32'd0}, 32, 48);
    check({63'd0, saw_oe}, 64'd0);
    quad_command_mode = 1'b1;
    cyc(3);
    check({62'd0, wrap_length_field}, 64'd2);
    for (int i = 0; i < 4; i++) begin
      fr({OP_SET_PARAM, 2'b00, 2'(i), 2'b00, 2'(3-i), 48'd0}, 16, 16);
      check({60'd0, dummy_count_field, wrap_length_field},
        {60'd0, 2'(i), 2'(3-i)});
      len = 8 << (3 - i);
      fr({OP_BURST_WRAP, 24'h00_00FC, 32'd0}, 32, 98 + 2 * i);
      for (int k = 0; k < 8; k++) begin
        e = {e[55:0], (k < 4 ? 8'(252 + k) : 8'(252 - len + k)) ^ 8'h5A};
      end
      check(rx[63:0], e);
    end
    // move both fields off their reset values so the reset is visible
    fr({OP_SET_PARAM, 8'h33, 48'd0}, 16, 16);
    check({60'd0, dummy_count_field, wrap_length_field},
      64'h0000_0000_0000_000F);
    reset_command = 1'b1;
    cyc(1);
    reset_command = 1'b0;
    cyc(3);
    check({60'd0, dummy_count_field, wrap_length_field}, 64'd0);
    close_out();
  end
endmodule : tb_fis_core
